// ==== logic/reset_seq_pkg.sv ====
// Package for the fundamental reset and boot sequencer.
// Assumes a 50 MHz mclk; the training and retry counts are derived from it here.
package reset_seq_pkg;
	localparam int          CLK_MHZ          = 50;
	localparam int          TRAIN_LIMIT_MS   = 20;
	localparam int          RETRY_LIMIT_MS   = 100;
	localparam int          EEPROM_LIMIT_MS  = 200;
	localparam int          TRAIN_CYCLES     = TRAIN_LIMIT_MS * 1000 * CLK_MHZ;
	localparam int          RETRY_CYCLES     = RETRY_LIMIT_MS * 1000 * CLK_MHZ;
	localparam int          PLL_LOCK_CYCLES  = 16;
	localparam int          MODE_W           = 3;
	localparam logic [2:0]  MODE_NORMAL      = 3'h0;
	localparam logic [2:0]  MODE_EEPROM      = 3'h1;
	localparam int          DS_PORTS         = 2;
	localparam int          PORTS            = 3;
	localparam int          ERR_W            = 4;
	localparam logic [3:0]  ERR_NONE         = 4'h0;
	localparam logic [3:0]  ERR_BAD_MODE     = 4'h1;
	localparam int          BOOT_W           = 7;

	typedef enum logic [2:0] {
		ST_WAIT   = 3'b000,
		ST_SAMPLE = 3'b001,
		ST_PLL    = 3'b011,
		ST_TRAIN  = 3'b010,
		ST_LOAD   = 3'b110,
		ST_HALT   = 3'b111,
		ST_RUN    = 3'b101
	} seq_state_t;
endpackage : reset_seq_pkg

// ==== logic/boot_capture.sv ====
// Captures the boot configuration vector on the rising edge of the reset pin.
// Assumes the pin levels are synchronous to mclk.
`timescale 1ns/100ps
`default_nettype none
module boot_capture
	import reset_seq_pkg::*;
(
	input  wire logic                                  mclk,
	input  wire logic                                  reset_n,
	input  wire logic                                  fundamental_reset_in_n,
	input  wire logic                                  common_clock_downstream,
	input  wire logic                                  common_clock_upstream,
	input  wire logic                                  reset_halt,
	input  wire logic [reset_seq_pkg::MODE_W-1:0]      switch_mode_select,
	input  wire logic                                  aux_power_disable_n,
	output logic      [reset_seq_pkg::BOOT_W-1:0]      boot_vector,
	output logic                                       boot_sampled
);
	logic pin_prev;
	wire  pin_release = fundamental_reset_in_n & ~pin_prev;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			pin_prev <= 1'b0;
		else
			pin_prev <= fundamental_reset_in_n;
	end

	// Vector survives warm resets, so only the pin edge reloads it
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			boot_vector  <= '0;
			boot_sampled <= 1'b0;
		end else begin
			boot_sampled <= pin_release;
			if (pin_release)
				boot_vector <= {aux_power_disable_n, switch_mode_select, reset_halt,
					common_clock_upstream, common_clock_downstream};
		end
	end
endmodule : boot_capture
`default_nettype wire

// ==== logic/delay_timer.sv ====
// Down-counting timer that flags expiry after a programmed cycle count.
// Assumes start is a one-cycle pulse; restart reloads the count.
`timescale 1ns/100ps
`default_nettype none
module delay_timer #(
	parameter int COUNT = 16
) (
	input  wire logic  mclk,
	input  wire logic  reset_n,
	input  wire logic  start,
	output logic       expired
);
	localparam int W = $clog2(COUNT + 1);
	logic [W-1:0] remain;
	logic         running;

	initial begin
		if (COUNT < 1)
			$error("delay_timer COUNT must be at least one");
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			remain  <= '0;
			running <= 1'b0;
			expired <= 1'b0;
		end else if (start) begin
			remain  <= W'(COUNT - 1);
			running <= 1'b1;
			expired <= 1'b0;
		end else if (running) begin
			if (remain == '0) begin
				running <= 1'b0;
				expired <= 1'b1;
			end else
				remain <= remain - 1'b1;
		end
	end
endmodule : delay_timer
`default_nettype wire

// ==== logic/fundamental_reset_seq.sv ====
// Fundamental reset and boot initialization sequencer of a three-port switch.
// Assumes mclk is the core clock from the on-chip PLL and that the EEPROM
// loader, SMBus master and stacks are outside, talking over plain ports.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Sample boot vector only at reset release
// - Downstream common clock seeds slot clock bits
// - Upstream common clock seeds writable slot bit
// - Reset-halt pin parks device, SMBus active
// - Mode 0 normal, 1 EEPROM, others reserved
// - Aux disable low clears fundamental sticky bits
// - Status shows vector from last cold reset
// - Pin or software bit starts fundamental reset
// - Fundamental reset clears logic and stickies, except the boot vector and status
// - Warm software reset reuses old boot vector
// - Sample, decode, PLL, then start link training
// - Reset-halt pin sets status halt indication
// - Quasi-reset stacks, training within 20 ms
// - Config retry completions within 100 ms
// - EEPROM mode loads registers over SMBus
// - EEPROM retrain write retrains that port
// - Load error aborts, sets halt, logs error
// - Done flag on load finish or error
// - Halt bit holds logic until cleared
// - Load side effects act at the write
// - Complete software reset write before resetting
// - General purpose pins revert to inputs
// - Core clock from reference through on-chip PLL
module fundamental_reset_seq
	import reset_seq_pkg::*;
#(
	parameter int TRAIN_TIMEOUT = reset_seq_pkg::TRAIN_CYCLES,
	parameter int RETRY_TIMEOUT = reset_seq_pkg::RETRY_CYCLES,
	parameter int GPIO_W        = 5
) (
	input  wire logic                                  mclk,
	input  wire logic                                  reset_n,
	input  wire logic                                  fundamental_reset_in_n,
	input  wire logic                                  common_clock_downstream,
	input  wire logic                                  common_clock_upstream,
	input  wire logic                                  reset_halt,
	input  wire logic [reset_seq_pkg::MODE_W-1:0]      switch_mode_select,
	input  wire logic                                  aux_power_disable_n,
	input  wire logic                                  fundamental_reset_request,
	input  wire logic                                  request_completion_sent,
	input  wire logic                                  halt_clear,
	input  wire logic                                  pll_locked,
	input  wire logic                                  slot_clock_write,
	input  wire logic [reset_seq_pkg::PORTS-1:0]       slot_clock_wdata,
	input  wire logic                                  load_write,
	input  wire logic [reset_seq_pkg::PORTS-1:0]       full_link_retrain,
	input  wire logic                                  load_done,
	input  wire logic                                  load_error,
	input  wire logic [reset_seq_pkg::ERR_W-1:0]       load_error_code,
	output logic                                       pll_enable,
	output logic                                       serdes_enable,
	output logic                                       link_train_enable,
	output logic      [reset_seq_pkg::PORTS-1:0]       link_retrain,
	output logic                                       stack_reset_n,
	output logic                                       config_retry,
	output logic                                       core_reset_n,
	output logic                                       smbus_enable,
	output logic                                       load_start,
	output logic                                       sticky_clear,
	output logic                                       aux_power_enable,
	output logic      [reset_seq_pkg::PORTS-1:0]       link_status_slot_clock,
	output logic      [reset_seq_pkg::BOOT_W-1:0]      switch_status_reg,
	output logic                                       status_halt,
	output logic                                       control_halt,
	output logic                                       smbus_done,
	output logic      [reset_seq_pkg::ERR_W-1:0]       smbus_error,
	output logic                                       mode_reserved,
	output logic      [GPIO_W-1:0]                     gpio_out_en,
	output logic                                       train_late,
	output logic                                       retry_late
);
	initial begin
		if (GPIO_W < 1 || TRAIN_TIMEOUT < 1 || RETRY_TIMEOUT < TRAIN_TIMEOUT)
			$error("fundamental_reset_seq parameters out of range");
	end

	seq_state_t state;
	seq_state_t next_state;

	logic [BOOT_W-1:0] boot_vector;
	logic              boot_sampled;
	logic              boot_valid;
	logic              soft_pending;
	logic              soft_reset;
	logic              pll_done;
	logic              train_expired;
	logic              retry_expired;
	logic              seq_start;
	logic              train_seen;

	boot_capture u_boot (
		.mclk                    (mclk),
		.reset_n                 (reset_n),
		.fundamental_reset_in_n  (fundamental_reset_in_n),
		.common_clock_downstream (common_clock_downstream),
		.common_clock_upstream   (common_clock_upstream),
		.reset_halt              (reset_halt),
		.switch_mode_select      (switch_mode_select),
		.aux_power_disable_n     (aux_power_disable_n),
		.boot_vector             (boot_vector),
		.boot_sampled            (boot_sampled)
	);

	// Field views of the captured vector
	wire              boot_ccds  = boot_vector[0];
	wire              boot_ccus  = boot_vector[1];
	wire              boot_halt  = boot_vector[2];
	wire [MODE_W-1:0] boot_mode  = boot_vector[5:3];
	wire              boot_auxen = boot_vector[6];

	function automatic logic mode_is_eeprom(input logic [MODE_W-1:0] m);
		return m == MODE_EEPROM;
	endfunction

	function automatic logic mode_is_bad(input logic [MODE_W-1:0] m);
		return (m != MODE_NORMAL) && (m != MODE_EEPROM);
	endfunction

	// Software request is held until its write completion has left
	wire soft_fire    = soft_pending & request_completion_sent;
	wire source_busy  = ~fundamental_reset_in_n | soft_reset;
	wire in_seq_reset = (state == ST_WAIT) | source_busy;
	wire load_mode    = mode_is_eeprom(boot_mode);
	wire quasi        = (state == ST_TRAIN) | (state == ST_LOAD) | (state == ST_HALT);

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			soft_pending <= 1'b0;
			soft_reset   <= 1'b0;
		end else begin
			if (fundamental_reset_request)
				soft_pending <= 1'b1;
			else if (soft_fire)
				soft_pending <= 1'b0;
			soft_reset <= soft_fire;
		end
	end

	// Sequence may only leave the wait state once a vector exists
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			boot_valid <= 1'b0;
		else if (boot_sampled)
			boot_valid <= 1'b1;
	end

	delay_timer #(.COUNT(PLL_LOCK_CYCLES)) u_pll_timer (
		.mclk    (mclk),
		.reset_n (reset_n),
		.start   (seq_start),
		.expired (pll_done)
	);

	delay_timer #(.COUNT(TRAIN_TIMEOUT)) u_train_timer (
		.mclk    (mclk),
		.reset_n (reset_n),
		.start   (seq_start),
		.expired (train_expired)
	);

	delay_timer #(.COUNT(RETRY_TIMEOUT)) u_retry_timer (
		.mclk    (mclk),
		.reset_n (reset_n),
		.start   (seq_start),
		.expired (retry_expired)
	);

	// Lock wait is the slower of the PLL flag and a fixed minimum
	wire pll_ready = pll_done & pll_locked;

	always_comb begin
		next_state = state;
		case (state)
			ST_WAIT: begin
				if (!source_busy && boot_valid)
					next_state = ST_SAMPLE;
			end
			ST_SAMPLE: next_state = ST_PLL;
			ST_PLL: begin
				if (pll_ready)
					next_state = ST_TRAIN;
			end
			ST_TRAIN: begin
				if (load_mode)
					next_state = ST_LOAD;
				else if (control_halt)
					next_state = ST_HALT;
				else
					next_state = ST_RUN;
			end
			ST_LOAD: begin
				if (load_error)
					next_state = ST_HALT;
				else if (load_done)
					next_state = control_halt ? ST_HALT : ST_RUN;
			end
			ST_HALT: begin
				if (!control_halt)
					next_state = ST_RUN;
			end
			ST_RUN:  next_state = ST_RUN;
			default: next_state = ST_WAIT;
		endcase
		if (source_busy)
			next_state = ST_WAIT;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			state <= ST_WAIT;
		else
			state <= next_state;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			seq_start <= 1'b0;
		else
			seq_start <= (state == ST_WAIT) && (next_state == ST_SAMPLE);
	end

	// Halt control: seeded from the pin, set by a load error, cleared by agent
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			control_halt <= 1'b0;
			status_halt  <= 1'b0;
		end else if (in_seq_reset) begin
			control_halt <= 1'b0;
			status_halt  <= 1'b0;
		end else if (state == ST_SAMPLE) begin
			control_halt <= boot_halt;
			status_halt  <= boot_halt;
		end else if (state == ST_LOAD && load_error) begin
			control_halt <= 1'b1;
		end else if (halt_clear) begin
			control_halt <= 1'b0;
		end
	end

	// Load status; the done flag holds until the next fundamental reset
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			smbus_done  <= 1'b0;
			smbus_error <= ERR_NONE;
			load_start  <= 1'b0;
		end else if (in_seq_reset) begin
			smbus_done  <= 1'b0;
			smbus_error <= ERR_NONE;
			load_start  <= 1'b0;
		end else begin
			load_start <= (state == ST_TRAIN) && load_mode;
			if (state == ST_LOAD && load_error) begin
				smbus_done  <= 1'b1;
				smbus_error <= load_error_code;
			end else if (state == ST_LOAD && load_done)
				smbus_done <= 1'b1;
		end
	end

	// Slot clock bits: down ports in low bits, upstream port on top
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			link_status_slot_clock <= '0;
		else if (state == ST_SAMPLE)
			link_status_slot_clock <= {boot_ccus, {DS_PORTS{boot_ccds}}};
		else if (slot_clock_write && !in_seq_reset)
			link_status_slot_clock <= slot_clock_wdata;
	end

	// Retrain pulses leave in the cycle after the load write, not at the end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			link_retrain <= '0;
		else if (state == ST_LOAD && load_write)
			link_retrain <= full_link_retrain;
		else
			link_retrain <= '0;
	end

	// Status register only reloads after a pin reset
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			switch_status_reg <= '0;
		else if (boot_sampled)
			switch_status_reg <= boot_vector;
	end

	// Watch flags show a missed deadline; stale expiry is ignored while timers restart
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			train_seen <= 1'b0;
			train_late <= 1'b0;
			retry_late <= 1'b0;
		end else if (in_seq_reset) begin
			train_seen <= 1'b0;
			train_late <= 1'b0;
			retry_late <= 1'b0;
		end else begin
			if (quasi)
				train_seen <= 1'b1;
			if (train_expired && !train_seen && !seq_start)
				train_late <= 1'b1;
			if (retry_expired && !train_seen && !seq_start)
				retry_late <= 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pll_enable        <= 1'b0;
			serdes_enable     <= 1'b0;
			link_train_enable <= 1'b0;
			stack_reset_n     <= 1'b0;
			config_retry      <= 1'b0;
			core_reset_n      <= 1'b0;
			sticky_clear      <= 1'b1;
			aux_power_enable  <= 1'b0;
			mode_reserved     <= 1'b0;
		end else begin
			pll_enable        <= !in_seq_reset;
			serdes_enable     <= !in_seq_reset && state != ST_SAMPLE;
			link_train_enable <= quasi || state == ST_RUN;
			stack_reset_n     <= quasi || state == ST_RUN;
			config_retry      <= quasi;
			core_reset_n      <= state == ST_RUN;
			sticky_clear      <= in_seq_reset || (state == ST_SAMPLE && !boot_auxen);
			aux_power_enable  <= !in_seq_reset && boot_auxen;
			mode_reserved     <= !in_seq_reset && mode_is_bad(boot_mode);
		end
	end

	// Master SMBus stays alive through halt and load
	assign smbus_enable = ~in_seq_reset;

	// General pins are held as inputs; the output enables never leave zero
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			gpio_out_en <= '0;
		else
			gpio_out_en <= '0;
	end
endmodule : fundamental_reset_seq
`default_nettype wire

// ==== tb/reset_seq_checker_properties.sv ====
// Concurrent checks on the ports of the fundamental reset sequencer.
// Assumes a single mclk domain; bound onto every instance of the top module.
`timescale 1ns/100ps
`default_nettype none
module reset_seq_checker
	import reset_seq_pkg::*;
#(
	parameter int TRAIN_TIMEOUT = 40,
	parameter int RETRY_TIMEOUT = 200,
	parameter int GPIO_W        = 5
) (
	input wire logic                           mclk,
	input wire logic                           reset_n,
	input wire logic                           fundamental_reset_in_n,
	input wire logic                           fundamental_reset_request,
	input wire logic                           request_completion_sent,
	input wire logic                           load_write,
	input wire logic [reset_seq_pkg::PORTS-1:0] full_link_retrain,
	input wire logic                           load_done,
	input wire logic                           load_error,
	input wire logic [reset_seq_pkg::ERR_W-1:0] load_error_code,
	input wire logic                           pll_enable,
	input wire logic                           serdes_enable,
	input wire logic                           link_train_enable,
	input wire logic [reset_seq_pkg::PORTS-1:0] link_retrain,
	input wire logic                           stack_reset_n,
	input wire logic                           config_retry,
	input wire logic                           core_reset_n,
	input wire logic                           load_start,
	input wire logic [reset_seq_pkg::BOOT_W-1:0] switch_status_reg,
	input wire logic                           control_halt,
	input wire logic                           smbus_done,
	input wire logic [reset_seq_pkg::ERR_W-1:0] smbus_error,
	input wire logic [GPIO_W-1:0]              gpio_out_en
);
	logic [15:0] clear_cnt;

	// Restarts on any reset source so deadlines count from the moment it clears
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			clear_cnt <= 16'h0;
		else if (!fundamental_reset_in_n || fundamental_reset_request || request_completion_sent)
			clear_cnt <= 16'h0;
		else if (clear_cnt != 16'hffff)
			clear_cnt <= clear_cnt + 16'h1;
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	sequence pin_held;
		!fundamental_reset_in_n [*4];
	endsequence
	sequence done_seen;
		load_done ##1 smbus_done;
	endsequence

	gpio_input_a: assert property (gpio_out_en == '0)
		else $error("gpio output enable driven");
	hold_reset_a: assert property (pin_held |-> !pll_enable && !core_reset_n && !link_train_enable)
		else $error("logic not held while pin reset active");
	strap_window_a: assert property ($changed(switch_status_reg) |-> clear_cnt <= 16'h5)
		else $error("boot status moved away from pin release");
	train_deadline_a: assert property (clear_cnt > TRAIN_TIMEOUT |-> link_train_enable || core_reset_n)
		else $error("link training late");
	retry_deadline_a: assert property (clear_cnt > RETRY_TIMEOUT |-> config_retry || core_reset_n)
		else $error("config retry late");
	train_order_a: assert property ($rose(link_train_enable) |-> pll_enable && serdes_enable && stack_reset_n)
		else $error("training before pll and serdes");
	retrain_cause_a: assert property (link_retrain != '0 |-> $past(load_write) && link_retrain == $past(full_link_retrain))
		else $error("retrain without matching load write");
	load_mode_a: assert property (load_start |-> switch_status_reg[5:3] == MODE_EEPROM)
		else $error("load started outside eeprom mode");
	load_done_a: assert property (load_done |-> done_seen)
		else $error("done flag missing after load");
	load_error_a: assert property (load_error |=> smbus_done && control_halt && smbus_error == $past(load_error_code))
		else $error("load error not recorded");
	halt_hold_a: assert property (control_halt |-> !core_reset_n)
		else $error("core released while halted");
endmodule : reset_seq_checker

bind fundamental_reset_seq reset_seq_checker #(.TRAIN_TIMEOUT(TRAIN_TIMEOUT),
	.RETRY_TIMEOUT(RETRY_TIMEOUT), .GPIO_W(GPIO_W)) checker_inst (.*);
`default_nettype wire

// ==== tb/eeprom_model.sv ====
// Behavioural serial EEPROM loader standing behind the master SMBus.
// Assumes load_start is a one-cycle pulse; stall sets how slowly it answers.
`timescale 1ns/100ps
`default_nettype none
module eeprom_model (
	input  wire logic       mclk,
	input  wire logic       reset_n,
	input  wire logic       load_start,
	input  wire logic       fail,
	input  wire logic [3:0] stall,
	input  wire logic [2:0] retrain,
	input  wire logic [3:0] err_code,
	output logic            load_write,
	output logic      [2:0] full_link_retrain,
	output logic            load_done,
	output logic            load_error,
	output logic      [3:0] load_error_code
);
	logic       busy;
	logic [4:0] cnt;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			busy <= 1'b0;
			cnt <= 5'h0;
			load_write <= 1'b0;
			load_done <= 1'b0;
			load_error <= 1'b0;
			full_link_retrain <= 3'h0;
			load_error_code <= 4'h0;
		end else begin
			load_write <= 1'b0;
			load_done <= 1'b0;
			load_error <= 1'b0;
			// Unqualified data inverts every cycle, so a stale sample shows up
			full_link_retrain <= ~full_link_retrain;
			load_error_code <= ~load_error_code;
			if (load_start) begin
				busy <= 1'b1;
				cnt <= 5'h0;
			end else if (busy) begin
				cnt <= cnt + 5'h1;
				if (cnt == {1'b0, stall}) begin
					load_write <= 1'b1;
					full_link_retrain <= retrain;
				end
				if (cnt == {stall, 1'b1}) begin
					busy <= 1'b0;
					load_done <= !fail;
					load_error <= fail;
					load_error_code <= err_code;
				end
			end
		end
	end
endmodule : eeprom_model
`default_nettype wire

// ==== tb/fundamental_reset_seq_test.sv ====
// Self-checking bench for the fundamental reset sequencer.
// Assumes the EEPROM model in tb/ and the checker bound from its own file.
`timescale 1ns/100ps
`default_nettype none
`define CHECK(got, exp) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
`define WAIT_FOR(c) begin n = 0; while (!(c) && n < 400) begin @(negedge mclk); n++; end \
	if (n >= 400) error_cnt++; end
module fundamental_reset_seq_test;
	import reset_seq_pkg::*;
	logic mclk, reset_n, fundamental_reset_in_n, common_clock_downstream, common_clock_upstream;
	logic reset_halt, aux_power_disable_n, fundamental_reset_request, request_completion_sent;
	logic halt_clear, pll_locked, slot_clock_write, load_write, load_done, load_error;
	logic [2:0] switch_mode_select, slot_clock_wdata, full_link_retrain, link_retrain, retrain;
	logic [3:0] load_error_code, smbus_error, err_code, stall;
	logic pll_enable, serdes_enable, link_train_enable, stack_reset_n, config_retry, fail;
	logic core_reset_n, smbus_enable, load_start, sticky_clear, aux_power_enable, status_halt;
	logic control_halt, smbus_done, mode_reserved, train_late, retry_late;
	logic [2:0] link_status_slot_clock;
	logic [6:0] switch_status_reg;
	logic [4:0] gpio_out_en;
	int error_cnt = 0, num_checks = 0, cyc = 0, clear_seen = 0;
	logic [6:0] corner [6] = '{7'h40, 7'h4b, 7'h48, 7'h44, 7'h78, 7'h11};

	fundamental_reset_seq #(.TRAIN_TIMEOUT(60), .RETRY_TIMEOUT(200)) dut (.*);
	eeprom_model model (.*);

	always #10 mclk = ~mclk;
	always @(posedge mclk) pll_locked <= pll_enable;
	// Only pulses after the wait step count, so the reset-time clear is left out
	always @(posedge mclk) if (reset_n && pll_enable === 1'b1 && sticky_clear === 1'b1) clear_seen++;
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			complete_run();
		end
	end

	function automatic logic [2:0] exp_slot(input logic [6:0] v);
		return {v[1], v[0], v[0]};
	endfunction : exp_slot
	function automatic logic exp_res(input logic [6:0] v);
		return v[5:3] >= 3'h2;
	endfunction : exp_res

	task automatic finish_boot(input logic ld, input logic fl, input logic hl);
		int n;
		if (ld) begin
			`WAIT_FOR(smbus_done === 1'b1)
			`CHECK(smbus_error, fl ? err_code : ERR_NONE)
		end
		`WAIT_FOR(core_reset_n === 1'b1 || control_halt === 1'b1)
		`CHECK(control_halt, (ld & fl) | hl)
		`CHECK(status_halt, hl)
		if (control_halt === 1'b1) begin
			repeat (8) @(negedge mclk);
			`CHECK({core_reset_n, smbus_enable, config_retry}, 3'b011)
			@(posedge mclk);
			halt_clear <= 1'b1;
			@(posedge mclk);
			halt_clear <= 1'b0;
			`WAIT_FOR(core_reset_n === 1'b1)
		end
		`CHECK(core_reset_n, 1'b1)
		`CHECK({train_late, retry_late}, 2'b00)
	endtask : finish_boot

	task automatic run_case(input logic [6:0] v, input logic f);
		int n;
		int c0;
		@(posedge mclk);
		fundamental_reset_in_n <= 1'b0;
		{aux_power_disable_n, switch_mode_select, reset_halt, common_clock_upstream,
			common_clock_downstream} <= v;
		fail <= f;
		stall <= 4'($urandom);
		retrain <= 3'($urandom);
		err_code <= 4'($urandom_range(1, 15));
		repeat (4) @(posedge mclk);
		fundamental_reset_in_n <= 1'b1;
		c0 = clear_seen;
		@(posedge mclk);
		// Straps move once captured; the vector must not follow them
		{aux_power_disable_n, switch_mode_select, reset_halt, common_clock_upstream,
			common_clock_downstream} <= ~v;
		`WAIT_FOR(link_train_enable === 1'b1)
		`CHECK({pll_enable, serdes_enable, stack_reset_n, config_retry}, 4'hf)
		`CHECK(switch_status_reg, v)
		`CHECK(link_status_slot_clock, exp_slot(v))
		`CHECK(aux_power_enable, v[6])
		`CHECK(clear_seen != c0, !v[6])
		`CHECK(mode_reserved, exp_res(v))
		finish_boot(v[5:3] == MODE_EEPROM, f, v[2]);
	endtask : run_case

	task automatic slot_write(input logic [2:0] d);
		@(posedge mclk);
		slot_clock_wdata <= d;
		slot_clock_write <= 1'b1;
		@(posedge mclk);
		slot_clock_write <= 1'b0;
		slot_clock_wdata <= ~d;
		@(negedge mclk);
		`CHECK(link_status_slot_clock, d)
	endtask : slot_write

	task automatic warm_reset;
		int n;
		logic [6:0] old;
		old = switch_status_reg;
		@(posedge mclk);
		fundamental_reset_request <= 1'b1;
		{aux_power_disable_n, switch_mode_select, reset_halt, common_clock_upstream,
			common_clock_downstream} <= 7'($urandom);
		@(posedge mclk);
		fundamental_reset_request <= 1'b0;
		repeat (6) @(negedge mclk);
		`CHECK(core_reset_n, 1'b1)
		@(posedge mclk);
		request_completion_sent <= 1'b1;
		@(posedge mclk);
		request_completion_sent <= 1'b0;
		`WAIT_FOR(core_reset_n === 1'b0)
		`CHECK(core_reset_n, 1'b0)
		`WAIT_FOR(link_train_enable === 1'b0)
		`WAIT_FOR(link_train_enable === 1'b1)
		`CHECK(switch_status_reg, old)
		finish_boot(old[5:3] == MODE_EEPROM, fail, old[2]);
	endtask : warm_reset

	task complete_run;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run

	initial begin
		logic [6:0] v;
		{mclk, reset_n, fundamental_reset_in_n, common_clock_downstream, common_clock_upstream} = '0;
		{reset_halt, aux_power_disable_n, fundamental_reset_request, request_completion_sent} = '0;
		{halt_clear, pll_locked, slot_clock_write, switch_mode_select, slot_clock_wdata} = '0;
		{fail, stall, retrain, err_code} = '0;
		void'($urandom(28361));
		repeat (16) @(posedge mclk);
		reset_n <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			v = (i < 6) ? corner[i] : 7'($urandom);
			run_case(v, i == 2 || (i >= 6 && $urandom_range(0, 1) == 1));
			slot_write(3'($urandom));
			$display("test %0d done, errors %0d", i, error_cnt);
		end
		warm_reset;
		$display("test warm done, errors %0d", error_cnt);
		complete_run();
	end
endmodule : fundamental_reset_seq_test
`default_nettype wire
